// ---- scr_pkg.sv ----
`default_nettype none
package scr_pkg;

    // ----------------------------------------------------------------
    // register addresses (word addresses on the configuration port)
    // ----------------------------------------------------------------
    localparam logic [8:0] ADDR_IDENTITY   = 9'h000;
    localparam logic [8:0] ADDR_RSVD_ONE   = 9'h001;
    localparam logic [8:0] ADDR_VARIANT    = 9'h002;
    localparam logic [8:0] ADDR_PLL_RST    = 9'h008;
    localparam logic [8:0] ADDR_CGEN_RST   = 9'h009;
    localparam logic [8:0] ADDR_ANA_RST    = 9'h00A;
    localparam logic [8:0] ADDR_PLL_CTRL   = 9'h010;
    localparam logic [8:0] ADDR_PLL_RSVD   = 9'h011;
    localparam logic [8:0] ADDR_IO_CTRL    = 9'h014;
    localparam logic [8:0] ADDR_LOCK_STAT  = 9'h018;
    localparam logic [8:0] ADDR_LOCK_RSV_A = 9'h01A;
    localparam logic [8:0] ADDR_LOCK_RSV_B = 9'h01B;
    localparam logic [8:0] ADDR_CGEN_CTRL  = 9'h020;
    localparam logic [8:0] ADDR_LOGIC_EN   = 9'h022;
    localparam logic [8:0] ADDR_CORE_PWR   = 9'h028;

    // ----------------------------------------------------------------
    // reset values and field layout
    // ----------------------------------------------------------------
    localparam logic [15:0] RST_VARIANT    = 16'h0000;
    localparam logic [15:0] RST_PLL_RST    = 16'h0099;
    localparam logic [15:0] RST_CGEN_RST   = 16'h0009;
    localparam logic [15:0] RST_ANA_RST    = 16'h0999;
    localparam logic [15:0] RST_PLL_CTRL   = 16'h0004;
    localparam logic [15:0] RST_PLL_RSVD   = 16'h2113;
    localparam logic [15:0] RST_IO_CTRL    = 16'h0000;
    localparam logic [15:0] RST_LOCK_RSV_A = 16'h2182;
    localparam logic [15:0] RST_LOCK_RSV_B = 16'h3D2D;
    localparam logic [15:0] RST_CGEN_CTRL  = 16'h0004;
    localparam logic [15:0] RST_LOGIC_EN   = 16'h0000;
    localparam logic [15:0] RST_CORE_PWR   = 16'h0000;
    localparam logic [15:0] ZERO_WORD      = 16'h0000;
    localparam logic [3:0]  HOLD_CODE      = 4'h9;
    localparam int          NUM_UNITS      = 6;

    // ----------------------------------------------------------------
    // field positions inside the register words
    // ----------------------------------------------------------------
    localparam int HOLD_W        = 4;  // one soft-reset hold code
    localparam int HOLD_LO       = 0;  // pll, clock generator and mux codes
    localparam int HOLD_MID      = 4;  // lock detector and front end codes
    localparam int HOLD_HI       = 8;  // serializer code
    localparam int BIT_PLL_PWR   = 0;
    localparam int BIT_PLL_EN    = 1;
    localparam int BIT_PLL_BYP   = 2;
    localparam int BIT_CLKIN_PWR = 0;
    localparam int BIT_LOCK      = 0;
    localparam int BIT_ANA_CLK   = 0;
    localparam int BIT_LOGIC_CLK = 1;
    localparam int BIT_SEL_PLL   = 2;
    localparam int BIT_EIGHT_BIT = 3;
    localparam int BIT_LOGIC_EN  = 0;
    localparam int BIT_CORE_PWR  = 0;
    localparam int BIT_MUX_PWR   = 1;
    localparam int VARIANT_LO    = 0;
    localparam int VARIANT_W     = 2;

    // ----------------------------------------------------------------
    // control outputs grouped for the analog and clock blocks
    // ----------------------------------------------------------------
    typedef struct packed {
        logic       pllPowerUp;
        logic       pllEnable;
        logic       pllBypass;
        logic       clockInPowerUp;
        logic       analogClkEn;
        logic       logicClkEn;
        logic       selectPll;
        logic       eightBitMode;
        logic       logicEnable;
        logic       corePowerUp;
        logic       muxPowerUp;
        logic [1:0] variant;
    } scr_ctrl_t;

endpackage : scr_pkg
`default_nettype wire

// ---- scr_regs.sv ----
// Notes on behaviour
// - each 4-bit hold code equal to nine keeps its unit in reset; all default nine.
// - pll control bit 0 powers the pll up when set; resets zero.
// - pll control bit 1 enables the pll; resets zero.
// - pll control bit 2 bypasses the pll; resets one.
// - io control bit 0 powers the clock input buffer; resets zero.
// - clock generator bit 0 enables analog clocks; resets zero.
// - clock generator bit 1 enables the logic clock; resets zero.
// - clock generator bit 2 selects pll output over serial clock; resets one.
// - clock generator bit 3 selects eight-bit conversion instead of ten; resets zero.
// - logic register bit 0 globally enables sensor logic; resets zero.
// - image core bit 0 powers the pixel core up; resets zero.
// - image core bit 1 powers the column multiplexer up; resets zero.
`timescale 1ns/10ps
`default_nettype none
module scr_regs #(
    parameter logic [15:0] IDENTITY_WORD = 16'hA5C3  // arbitrary value
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rstn,
    // configuration port
    input  wire logic             cfgWrEn,
    input  wire logic             cfgRdEn,
    input  wire logic [8:0]       cfgAddr,
    input  wire logic [15:0]      cfgWrData,
    output logic      [15:0]      cfgRdData,
    output logic                  cfgRdValid,
    // status from the analog side
    input  wire logic             pllLocked,
    // unit reset holds: pll, lock det, clkgen, mux, afe, serializer
    output logic [5:0]            unitInReset,
    // control levels
    output scr_pkg::scr_ctrl_t    ctrl
);
    import scr_pkg::*;

    // ----------------------------------------------------------------
    // register storage
    // ----------------------------------------------------------------
    logic [15:0] variantQ,  variantD;
    logic [15:0] pllRstQ,   pllRstD;
    logic [15:0] cgenRstQ,  cgenRstD;
    logic [15:0] anaRstQ,   anaRstD;
    logic [15:0] pllCtrlQ,  pllCtrlD;
    logic [15:0] pllRsvdQ,  pllRsvdD;
    logic [15:0] ioCtrlQ,   ioCtrlD;
    logic [15:0] lockRsvAQ, lockRsvAD;
    logic [15:0] lockRsvBQ, lockRsvBD;
    logic [15:0] cgenCtrlQ, cgenCtrlD;
    logic [15:0] logicEnQ,  logicEnD;
    logic [15:0] corePwrQ,  corePwrD;
    logic        lockQ,     lockD;
    logic [15:0] rdDataQ,   rdDataD;
    logic        rdValidQ,  rdValidD;
    logic [3:0]  holdCode [NUM_UNITS];

    // ----------------------------------------------------------------
    // chip configuration: product variant
    // ----------------------------------------------------------------
    // stored as written; matching it to the product is up to software
    always_comb begin
        variantD = variantQ;
        if (cfgWrEn && cfgAddr == ADDR_VARIANT) begin
            variantD = cfgWrData;
        end
    end

    // variant register
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            variantQ <= RST_VARIANT;
        end else begin
            variantQ <= variantD;
        end
    end

    // ----------------------------------------------------------------
    // reset generator: soft-reset hold codes
    // ----------------------------------------------------------------
    // full words kept so unused nibbles read back as written
    always_comb begin
        pllRstD  = pllRstQ;
        cgenRstD = cgenRstQ;
        anaRstD  = anaRstQ;
        if (cfgWrEn) begin
            unique case (cfgAddr)
                ADDR_PLL_RST:  pllRstD  = cfgWrData;
                ADDR_CGEN_RST: cgenRstD = cfgWrData;
                ADDR_ANA_RST:  anaRstD  = cfgWrData;
                default: ;  // owned by other groups
            endcase
        end
    end

    // hold code registers; every unit starts held
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pllRstQ  <= RST_PLL_RST;
            cgenRstQ <= RST_CGEN_RST;
            anaRstQ  <= RST_ANA_RST;
        end else begin
            pllRstQ  <= pllRstD;
            cgenRstQ <= cgenRstD;
            anaRstQ  <= anaRstD;
        end
    end

    // ----------------------------------------------------------------
    // pll: power, enable, bypass and reserved word
    // ----------------------------------------------------------------
    // reserved word kept writable so software can restore it
    always_comb begin
        pllCtrlD = pllCtrlQ;
        pllRsvdD = pllRsvdQ;
        if (cfgWrEn) begin
            unique case (cfgAddr)
                ADDR_PLL_CTRL: pllCtrlD = cfgWrData;
                ADDR_PLL_RSVD: pllRsvdD = cfgWrData;
                default: ;  // owned by other groups
            endcase
        end
    end

    // pll registers; the pll starts bypassed and powered down
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pllCtrlQ <= RST_PLL_CTRL;
            pllRsvdQ <= RST_PLL_RSVD;
        end else begin
            pllCtrlQ <= pllCtrlD;
            pllRsvdQ <= pllRsvdD;
        end
    end

    // ----------------------------------------------------------------
    // input/output: clock input buffer power
    // ----------------------------------------------------------------
    // single word, written whole
    always_comb begin
        ioCtrlD = ioCtrlQ;
        if (cfgWrEn && cfgAddr == ADDR_IO_CTRL) begin
            ioCtrlD = cfgWrData;
        end
    end

    // io register
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ioCtrlQ <= RST_IO_CTRL;
        end else begin
            ioCtrlQ <= ioCtrlD;
        end
    end

    // ----------------------------------------------------------------
    // lock detector: status flop and reserved words
    // ----------------------------------------------------------------
    // detector level is already synchronous, so one flop suffices
    always_comb begin
        lockD     = pllLocked;  // tracks the detector every cycle
        lockRsvAD = lockRsvAQ;
        lockRsvBD = lockRsvBQ;
        if (cfgWrEn) begin
            unique case (cfgAddr)
                ADDR_LOCK_RSV_A: lockRsvAD = cfgWrData;
                ADDR_LOCK_RSV_B: lockRsvBD = cfgWrData;
                default: ;  // the status word itself takes no write
            endcase
        end
    end

    // lock detector registers; lock reads zero until reported
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            lockQ     <= 1'b0;
            lockRsvAQ <= RST_LOCK_RSV_A;
            lockRsvBQ <= RST_LOCK_RSV_B;
        end else begin
            lockQ     <= lockD;
            lockRsvAQ <= lockRsvAD;
            lockRsvBQ <= lockRsvBD;
        end
    end

    // ----------------------------------------------------------------
    // clock generator: gating, source and conversion width
    // ----------------------------------------------------------------
    // single word, written whole
    always_comb begin
        cgenCtrlD = cgenCtrlQ;
        if (cfgWrEn && cfgAddr == ADDR_CGEN_CTRL) begin
            cgenCtrlD = cfgWrData;
        end
    end

    // clock generator register; pll source selected from reset
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cgenCtrlQ <= RST_CGEN_CTRL;
        end else begin
            cgenCtrlQ <= cgenCtrlD;
        end
    end

    // ----------------------------------------------------------------
    // general logic enable and image core power
    // ----------------------------------------------------------------
    // both words written whole
    always_comb begin
        logicEnD = logicEnQ;
        corePwrD = corePwrQ;
        if (cfgWrEn) begin
            unique case (cfgAddr)
                ADDR_LOGIC_EN: logicEnD = cfgWrData;
                ADDR_CORE_PWR: corePwrD = cfgWrData;
                default: ;  // owned by other groups
            endcase
        end
    end

    // logic and core registers; everything starts off
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            logicEnQ <= RST_LOGIC_EN;
            corePwrQ <= RST_CORE_PWR;
        end else begin
            logicEnQ <= logicEnD;
            corePwrQ <= corePwrD;
        end
    end

    // ----------------------------------------------------------------
    // read port; the identity word has no storage, so writes vanish
    // ----------------------------------------------------------------
    // registered mux: one cycle of latency buys a clean data word
    always_comb begin
        rdValidD = cfgRdEn;
        rdDataD  = rdDataQ;
        if (cfgRdEn) begin
            unique case (cfgAddr)
                ADDR_IDENTITY:   rdDataD = IDENTITY_WORD;
                ADDR_VARIANT:    rdDataD = variantQ;
                ADDR_PLL_RST:    rdDataD = pllRstQ;
                ADDR_CGEN_RST:   rdDataD = cgenRstQ;
                ADDR_ANA_RST:    rdDataD = anaRstQ;
                ADDR_PLL_CTRL:   rdDataD = pllCtrlQ;
                ADDR_PLL_RSVD:   rdDataD = pllRsvdQ;
                ADDR_IO_CTRL:    rdDataD = ioCtrlQ;
                ADDR_LOCK_STAT: begin
                    rdDataD           = ZERO_WORD;
                    rdDataD[BIT_LOCK] = lockQ;
                end
                ADDR_LOCK_RSV_A: rdDataD = lockRsvAQ;
                ADDR_LOCK_RSV_B: rdDataD = lockRsvBQ;
                ADDR_CGEN_CTRL:  rdDataD = cgenCtrlQ;
                ADDR_LOGIC_EN:   rdDataD = logicEnQ;
                ADDR_CORE_PWR:   rdDataD = corePwrQ;
                default:         rdDataD = ZERO_WORD;  // address 001 and unmapped read zero
            endcase
        end
    end

    // read port registers; data holds until the next read
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdDataQ  <= ZERO_WORD;
            rdValidQ <= 1'b0;
        end else begin
            rdDataQ  <= rdDataD;
            rdValidQ <= rdValidD;
        end
    end

    // ----------------------------------------------------------------
    // unit reset holds: only the exact code nine holds a unit
    // ----------------------------------------------------------------
    assign holdCode[0] = pllRstQ[HOLD_LO +: HOLD_W];
    assign holdCode[1] = pllRstQ[HOLD_MID +: HOLD_W];
    assign holdCode[2] = cgenRstQ[HOLD_LO +: HOLD_W];
    assign holdCode[3] = anaRstQ[HOLD_LO +: HOLD_W];
    assign holdCode[4] = anaRstQ[HOLD_MID +: HOLD_W];
    assign holdCode[5] = anaRstQ[HOLD_HI +: HOLD_W];

    for (genvar u = 0; u < NUM_UNITS; u++) begin : g_hold
        assign unitInReset[u] = (holdCode[u] == HOLD_CODE);
    end

    // ----------------------------------------------------------------
    // control levels straight from register bits
    // ----------------------------------------------------------------
    assign ctrl.pllPowerUp     = pllCtrlQ[BIT_PLL_PWR];
    assign ctrl.pllEnable      = pllCtrlQ[BIT_PLL_EN];
    assign ctrl.pllBypass      = pllCtrlQ[BIT_PLL_BYP];
    assign ctrl.clockInPowerUp = ioCtrlQ[BIT_CLKIN_PWR];
    assign ctrl.analogClkEn    = cgenCtrlQ[BIT_ANA_CLK];
    assign ctrl.logicClkEn     = cgenCtrlQ[BIT_LOGIC_CLK];
    assign ctrl.selectPll      = cgenCtrlQ[BIT_SEL_PLL];
    assign ctrl.eightBitMode   = cgenCtrlQ[BIT_EIGHT_BIT];
    assign ctrl.logicEnable    = logicEnQ[BIT_LOGIC_EN];
    assign ctrl.corePowerUp    = corePwrQ[BIT_CORE_PWR];
    assign ctrl.muxPowerUp     = corePwrQ[BIT_MUX_PWR];
    assign ctrl.variant        = variantQ[VARIANT_LO +: VARIANT_W];

    assign cfgRdData  = rdDataQ;
    assign cfgRdValid = rdValidQ;

endmodule : scr_regs
`default_nettype wire

// ---- scr_regs_checker.sv ----
`timescale 1ns/10ps
`default_nettype none
module scr_regs_checker #(
    parameter logic [15:0] IDENTITY_WORD = 16'hA5C3  // arbitrary value
) (
    // clock and reset
    input wire logic               clk,
    input wire logic               rstn,
    // configuration port
    input wire logic               cfgWrEn,
    input wire logic               cfgRdEn,
    input wire logic [8:0]         cfgAddr,
    input wire logic [15:0]        cfgWrData,
    input wire logic [15:0]        cfgRdData,
    input wire logic               cfgRdValid,
    // status and control levels
    input wire logic               pllLocked,
    input wire logic [5:0]         unitInReset,
    input wire scr_pkg::scr_ctrl_t ctrl
);
    import scr_pkg::*;

    // ----------------------------------------------------------------
    // write and read consequences, one cycle after the strobe
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    property p_hold; cfgWrEn && cfgAddr == ADDR_PLL_RST |=> unitInReset[1:0] ==
        {$past(cfgWrData[7:4]) == HOLD_CODE, $past(cfgWrData[3:0]) == HOLD_CODE}; endproperty
    a_hold: assert property (p_hold) else $error("pll hold level wrong");
    property p_ana; cfgWrEn && cfgAddr == ADDR_ANA_RST |=> unitInReset[5:3] == {$past(cfgWrData[11:8]) ==
        HOLD_CODE, $past(cfgWrData[7:4]) == HOLD_CODE, $past(cfgWrData[3:0]) == HOLD_CODE}; endproperty
    a_ana: assert property (p_ana) else $error("analog hold level wrong");
    property p_pll; cfgWrEn && cfgAddr == ADDR_PLL_CTRL |=>
        {ctrl.pllBypass, ctrl.pllEnable, ctrl.pllPowerUp} == $past(cfgWrData[2:0]); endproperty
    a_pll: assert property (p_pll) else $error("pll control wrong");
    property p_io; cfgWrEn && cfgAddr == ADDR_IO_CTRL |=> ctrl.clockInPowerUp == $past(cfgWrData[0]); endproperty
    a_io: assert property (p_io) else $error("clock input power wrong");
    property p_lock; cfgRdEn && cfgAddr == ADDR_LOCK_STAT |=> cfgRdValid && cfgRdData[0] == $past(pllLocked, 2);
    endproperty
    a_lock: assert property (p_lock) else $error("lock status wrong");
    property p_cgen; cfgWrEn && cfgAddr == ADDR_CGEN_CTRL |=> {ctrl.eightBitMode, ctrl.selectPll,
        ctrl.logicClkEn, ctrl.analogClkEn} == $past(cfgWrData[3:0]); endproperty
    a_cgen: assert property (p_cgen) else $error("clock generator wrong");
    property p_logic; cfgWrEn && cfgAddr == ADDR_LOGIC_EN |=> ctrl.logicEnable == $past(cfgWrData[0]); endproperty
    a_logic: assert property (p_logic) else $error("logic enable wrong");
    property p_core; cfgWrEn && cfgAddr == ADDR_CORE_PWR |=>
        {ctrl.muxPowerUp, ctrl.corePowerUp} == $past(cfgWrData[1:0]); endproperty
    a_core: assert property (p_core) else $error("core power wrong");
    property p_id; cfgRdEn && cfgAddr == ADDR_IDENTITY |=> cfgRdValid && cfgRdData == IDENTITY_WORD; endproperty
    a_id: assert property (p_id) else $error("identity word wrong");

    // main scenarios reached
    c_lock: cover property (cfgRdValid && cfgRdData[0]);
    c_free: cover property (unitInReset == 6'h00);
    c_pll: cover property (!ctrl.pllBypass && ctrl.pllEnable);
endmodule : scr_regs_checker

bind scr_regs scr_regs_checker #(.IDENTITY_WORD(IDENTITY_WORD)) scr_regs_checker_i (.clk(clk), .rstn(rstn),
    .cfgWrEn(cfgWrEn), .cfgRdEn(cfgRdEn), .cfgAddr(cfgAddr), .cfgWrData(cfgWrData), .cfgRdData(cfgRdData),
    .cfgRdValid(cfgRdValid), .pllLocked(pllLocked), .unitInReset(unitInReset), .ctrl(ctrl));
`default_nettype wire

// ---- testbench.sv ----
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import scr_pkg::*;
    localparam logic [15:0] ID = 16'h5A3C;  // arbitrary value
    logic        clk, rstn, cfgWrEn, cfgRdEn, pllLocked, cfgRdValid;
    logic [8:0]  cfgAddr;
    logic [15:0] cfgWrData, cfgRdData;
    logic [5:0]  unitInReset;
    scr_ctrl_t   ctrl;
    int          n_mismatch = 0;
    int          num_checks = 0;

    scr_regs #(.IDENTITY_WORD(ID)) scr_regs_i (.clk(clk), .rstn(rstn), .cfgWrEn(cfgWrEn), .cfgRdEn(cfgRdEn),
        .cfgAddr(cfgAddr), .cfgWrData(cfgWrData), .cfgRdData(cfgRdData), .cfgRdValid(cfgRdValid),
        .pllLocked(pllLocked), .unitInReset(unitInReset), .ctrl(ctrl));

    // ----------------------------------------------------------------
    // clock, compare and bus tasks
    // ----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    // inputs move on the falling edge, away from the sampling edge
    task automatic wr(input logic [8:0] a, input logic [15:0] d);
        @(negedge clk);
        cfgWrEn = 1'b1;
        cfgAddr = a;
        cfgWrData = d;
        @(negedge clk);
        cfgWrEn = 1'b0;
    endtask : wr
    task automatic rd(input logic [8:0] a, input logic [15:0] e);
        @(negedge clk);
        cfgRdEn = 1'b1;
        cfgAddr = a;
        @(negedge clk);
        cfgRdEn = 1'b0;
        check({15'h0, cfgRdValid}, 16'h0001);
        check(cfgRdData, e);
    endtask : rd
    task automatic do_reset;
        rstn = 1'b0;
        repeat (16) @(negedge clk);
        rstn = 1'b1;
    endtask : do_reset
    task automatic conclude;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : conclude

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset;
        logic [8:0]  ad [15] = '{9'h002, 9'h008, 9'h009, 9'h00A, 9'h010, 9'h011, 9'h014, 9'h018, 9'h01A,
                                 9'h01B, 9'h020, 9'h022, 9'h028, 9'h001, 9'h1FF};
        logic [15:0] ev [15] = '{16'h0, 16'h99, 16'h9, 16'h999, 16'h4, 16'h2113, 16'h0, 16'h0, 16'h2182,
                                 16'h3D2D, 16'h4, 16'h0, 16'h0, 16'h0, 16'h0};
        scr_ctrl_t e;
        e = '0;
        e.pllBypass = 1'b1;
        e.selectPll = 1'b1;
        check({3'h0, ctrl}, {3'h0, e});
        check({10'h0, unitInReset}, 16'h003F);
        for (int k = 0; k < 15; k++) rd(ad[k], ev[k]);
        rd(ADDR_IDENTITY, ID);
        $display("reset values done");
    endtask : t_reset
    task automatic t_hold;
        for (int c = 0; c < 16; c++) begin
            wr(ADDR_PLL_RST, {8'h0, c[3:0], c[3:0]});
            wr(ADDR_CGEN_RST, {12'h0, c[3:0]});
            wr(ADDR_ANA_RST, {4'h0, {3{c[3:0]}}});
            check({10'h0, unitInReset}, {10'h0, {6{c[3:0] == 4'h9}}});
        end
        wr(ADDR_PLL_RST, 16'h0093);
        wr(ADDR_ANA_RST, 16'h0391);
        check({10'h0, unitInReset}, 16'h0012);
        $display("hold codes done");
    endtask : t_hold
    task automatic t_ctrl(input logic [3:0] p, input logic [3:0] g, input logic [1:0] c, input logic i,
                          input logic l, input logic [1:0] v);
        scr_ctrl_t e;
        wr(ADDR_PLL_CTRL, {12'h0, p});
        wr(ADDR_CGEN_CTRL, {12'h0, g});
        wr(ADDR_IO_CTRL, {15'h0, i});
        wr(ADDR_LOGIC_EN, {15'h0, l});
        wr(ADDR_CORE_PWR, {14'h0, c});
        wr(ADDR_VARIANT, {14'h0, v});
        e = {p[0], p[1], p[2], i, g[0], g[1], g[2], g[3], l, c[0], c[1], v};
        check({3'h0, ctrl}, {3'h0, e});
        rd(ADDR_CGEN_CTRL, {12'h0, g});
        rd(ADDR_VARIANT, {14'h0, v});
        $display("control pattern done");
    endtask : t_ctrl
    task automatic t_ro;
        wr(ADDR_IDENTITY, 16'h0000);
        wr(ADDR_LOCK_STAT, 16'h0001);
        rd(ADDR_IDENTITY, ID);
        rd(ADDR_LOCK_STAT, 16'h0000);
        pllLocked = 1'b1;
        rd(ADDR_LOCK_STAT, 16'h0001);
        pllLocked = 1'b0;
        rd(ADDR_LOCK_STAT, 16'h0000);
        $display("read-only done");
    endtask : t_ro

    // watchdog far beyond the few hundred cycles the run needs
    initial begin
        #100000;
        n_mismatch++;
        conclude();
    end
    initial begin
        {cfgWrEn, cfgRdEn, pllLocked, cfgAddr, cfgWrData} = '0;
        do_reset();
        t_reset();
        t_hold();
        t_ctrl(4'h5, 4'hA, 2'h2, 1'b1, 1'b0, 2'h1);
        t_ctrl(4'h2, 4'h5, 2'h1, 1'b0, 1'b1, 2'h2);
        t_ro();
        do_reset();
        t_reset();
        conclude();
    end
endmodule : testbench
`default_nettype wire
